// ===== rtl/pmc_device.sv
// Power-mode control end: control register, idle, power-down, wake and reset lead
`timescale 1ns/1ps
module pmc_device
    import pmc_pkg::*;
#(
    parameter int MC_LEN = OSC_PER_MC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    pmc_if.dev LINK,
    output logic [1:0] MODE,
    output logic [2:0] STATE_IN_MC
);
    typedef struct packed {
        logic [7:0] power_control;
        logic [7:0] auxiliary_control;
        logic [7:0] rdata;
        mode_t mode;
        logic [3:0] osc_cnt;
        logic [1:0] lead_cnt;
        logic rst_s1;
        logic rst_s2;
        logic ia_s1;
        logic ia_s2;
        logic ib_s1;
        logic ib_s2;
        logic vcc_s1;
        logic vcc_s2;
        logic vcc_seen;
        logic int_reset;
    } dev_st_t;

    dev_st_t cur_ff;
    dev_st_t nxt_ff;
    logic mc_end;
    logic wake_lvl;
    logic wr_power_control;
    logic wr_auxiliary_control;

    // Decode of machine-cycle end and level-sensitive wake requests
    always_comb begin
        mc_end = (cur_ff.osc_cnt == 4'(MC_LEN - 1));
        wake_lvl = (LINK.irq_a_en && LINK.irq_a_level && !cur_ff.ia_s2)
            || (LINK.irq_b_en && LINK.irq_b_level && !cur_ff.ib_s2);
        wr_power_control = LINK.sfr_wr && (LINK.sfr_addr == POWER_CONTROL_ADDR);
        wr_auxiliary_control = LINK.sfr_wr && (LINK.sfr_addr == AUXILIARY_CONTROL_ADDR);
    end

    // Next state of the whole block
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rst_s1 = LINK.rst_pin;
        nxt_ff.rst_s2 = cur_ff.rst_s1;
        nxt_ff.ia_s1 = LINK.irq_a_n;
        nxt_ff.ia_s2 = cur_ff.ia_s1;
        nxt_ff.ib_s1 = LINK.irq_b_n;
        nxt_ff.ib_s2 = cur_ff.ib_s1;
        nxt_ff.vcc_s1 = LINK.vcc_up;
        nxt_ff.vcc_s2 = cur_ff.vcc_s1;
        // Oscillator period counter stops while frozen
        if (cur_ff.mode != MODE_PDOWN) begin
            nxt_ff.osc_cnt = mc_end ? 4'h0 : cur_ff.osc_cnt + 4'h1;
        end
        // Register writes; reserved bit kept at zero
        if (wr_power_control && cur_ff.mode == MODE_RUN) begin
            nxt_ff.power_control = LINK.sfr_wdata;
            nxt_ff.power_control[RSVD_BIT] = 1'b0;
        end
        if (wr_auxiliary_control) begin
            nxt_ff.auxiliary_control = LINK.sfr_wdata;
        end
        // Cold-start flag on supply rise, wins over a software clear
        if (cur_ff.vcc_s2 && !cur_ff.vcc_seen) begin
            nxt_ff.vcc_seen = 1'b1;
            nxt_ff.power_control[COLD_BIT] = 1'b1;
        end
        if (!cur_ff.vcc_s2) begin
            nxt_ff.vcc_seen = 1'b0;
        end
        // Register read data, captured
        if (LINK.sfr_rd) begin
            if (LINK.sfr_addr == POWER_CONTROL_ADDR) begin
                nxt_ff.rdata = cur_ff.power_control;
            end else if (LINK.sfr_addr == AUXILIARY_CONTROL_ADDR) begin
                nxt_ff.rdata = cur_ff.auxiliary_control;
            end else begin
                nxt_ff.rdata = 8'h00;
            end
        end
        nxt_ff.int_reset = 1'b0;
        case (cur_ff.mode)
            MODE_RUN: begin
                if (wr_power_control && LINK.sfr_wdata[PDOWN_BIT]) begin
                    nxt_ff.mode = MODE_PDOWN;
                end else if (wr_power_control && LINK.sfr_wdata[IDLE_BIT]) begin
                    nxt_ff.mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (LINK.rst_pin) begin
                    // Asynchronous-style clear from the raw pin
                    nxt_ff.power_control[IDLE_BIT] = 1'b0;
                    nxt_ff.mode = MODE_LEAD;
                    nxt_ff.lead_cnt = 2'd0;
                end else if (LINK.other_irq || wake_lvl) begin
                    nxt_ff.power_control[IDLE_BIT] = 1'b0;
                    nxt_ff.mode = MODE_RUN;
                end
            end
            MODE_PDOWN: begin
                if (cur_ff.rst_s2) begin
                    nxt_ff = '0;
                    nxt_ff.power_control[COLD_BIT] = cur_ff.power_control[COLD_BIT];
                    nxt_ff.vcc_seen = cur_ff.vcc_seen;
                    nxt_ff.int_reset = 1'b1;
                end else if (wake_lvl) begin
                    nxt_ff.power_control[PDOWN_BIT] = 1'b0;
                    nxt_ff.power_control[IDLE_BIT] = 1'b0;
                    nxt_ff.mode = MODE_RUN;
                end
            end
            MODE_LEAD: begin
                // Core runs a few machine cycles before reset takes over
                if (mc_end) begin
                    nxt_ff.lead_cnt = cur_ff.lead_cnt + 2'd1;
                    if (cur_ff.lead_cnt == 2'(RESET_LEAD_MC - 1)) begin
                        nxt_ff.mode = MODE_RUN;
                        nxt_ff.power_control = POWER_CONTROL_RESET | (cur_ff.power_control & (8'h01 << COLD_BIT));
                        nxt_ff.auxiliary_control = AUXILIARY_CONTROL_RESET;
                        nxt_ff.int_reset = 1'b1;
                    end
                end
            end
            default: begin
                nxt_ff.mode = MODE_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs toward core and pins
    always_comb begin
        LINK.sfr_rdata = cur_ff.rdata;
        LINK.core_clk_en = (cur_ff.mode == MODE_RUN) || (cur_ff.mode == MODE_LEAD);
        LINK.osc_run = (cur_ff.mode != MODE_PDOWN);
        LINK.ram_block = (cur_ff.mode == MODE_LEAD);
        LINK.int_reset = cur_ff.int_reset || SYS_RST;
        LINK.hold_ports = (cur_ff.mode == MODE_IDLE) || (cur_ff.mode == MODE_PDOWN);
        if (cur_ff.mode == MODE_PDOWN) begin
            LINK.ale_o = 1'b0;
            LINK.ale_oe = 1'b1;
            LINK.prog_store_strobe = 1'b0;
        end else if (cur_ff.mode == MODE_IDLE) begin
            LINK.ale_o = 1'b1;
            LINK.ale_oe = 1'b1;
            LINK.prog_store_strobe = 1'b1;
        end else begin
            LINK.ale_o = (cur_ff.osc_cnt < 4'h2) || (cur_ff.osc_cnt == 4'h6);
            LINK.ale_oe = !cur_ff.auxiliary_control[ALE_OFF_BIT] || LINK.ext_move || LINK.ext_exec;
            LINK.prog_store_strobe = 1'b1;
        end
        LINK.idle_flag = (cur_ff.mode == MODE_IDLE);
        LINK.pdown_flag = (cur_ff.mode == MODE_PDOWN);
        LINK.baud_doubler = cur_ff.power_control[BAUD_DBL_BIT];
        LINK.frame_err_select = cur_ff.power_control[FE_SEL_BIT];
        MODE = cur_ff.mode;
        STATE_IN_MC = 3'(cur_ff.osc_cnt >> 1);
    end
endmodule : pmc_device

// ===== inc/pmc_pkg.sv
// Shared constants and types for the power-mode control link
package pmc_pkg;
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] AUXILIARY_CONTROL_ADDR = 8'h8E;
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] AUXILIARY_CONTROL_RESET = 8'h00;
    localparam int IDLE_BIT = 0;
    localparam int PDOWN_BIT = 1;
    localparam int FLAG_A_BIT = 2;
    localparam int FLAG_B_BIT = 3;
    localparam int COLD_BIT = 4;
    localparam int RSVD_BIT = 5;
    localparam int FE_SEL_BIT = 6;
    localparam int BAUD_DBL_BIT = 7;
    localparam int ALE_OFF_BIT = 0;
    localparam int OSC_PER_STATE = 2;
    localparam int STATES_PER_MC = 6;
    localparam int OSC_PER_MC = OSC_PER_STATE * STATES_PER_MC;
    localparam int RESET_HOLD_MC = 2;
    localparam int RESET_HOLD_OSC = RESET_HOLD_MC * OSC_PER_MC;
    localparam int RESET_LEAD_MC = 3;
    // Oscillator restart allowance, in microseconds, and cycles at 10 MHz
    localparam int OSC_RESTART_US = 10000;
    localparam int CLK_MHZ = 10;
    localparam int OSC_RESTART_CYC = OSC_RESTART_US * CLK_MHZ;
    // Wishbone register map of the controller, byte addresses of its 32-bit registers
    localparam logic [3:0] WB_CMD_ADDR = 4'h0;
    localparam logic [3:0] WB_DATA_ADDR = 4'h4;
    localparam logic [3:0] WB_STAT_ADDR = 4'h8;
    localparam logic [3:0] WB_RESP_ADDR = 4'hC;
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_WRITE = 3'b001,
        CMD_READ = 3'b010,
        CMD_IRQ = 3'b011,
        CMD_RESET = 3'b100,
        CMD_POWER = 3'b101
    } cmd_t;
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_PDOWN = 2'b10,
        MODE_LEAD = 2'b11
    } mode_t;
endpackage : pmc_pkg

// ===== inc/pmc_if.sv
// Link between the power-mode block and the core/pin side that drives it
`timescale 1ns/1ps
interface pmc_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic rst_pin;
    logic irq_a_n;
    logic irq_b_n;
    logic irq_a_en;
    logic irq_b_en;
    logic irq_a_level;
    logic irq_b_level;
    logic other_irq;
    logic irq_return;
    logic vcc_up;
    logic ext_move;
    logic ext_exec;
    logic core_clk_en;
    logic osc_run;
    logic ram_block;
    logic int_reset;
    logic hold_ports;
    logic ale_o;
    logic ale_oe;
    logic prog_store_strobe;
    logic idle_flag;
    logic pdown_flag;
    logic baud_doubler;
    logic frame_err_select;
    modport dev (
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, rst_pin, irq_a_n, irq_b_n,
        input irq_a_en, irq_b_en, irq_a_level, irq_b_level, other_irq, irq_return,
        input vcc_up, ext_move, ext_exec,
        output sfr_rdata, core_clk_en, osc_run, ram_block, int_reset, hold_ports,
        output ale_o, ale_oe, prog_store_strobe, idle_flag, pdown_flag,
        output baud_doubler, frame_err_select
    );
    modport host (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, rst_pin, irq_a_n, irq_b_n,
        output irq_a_en, irq_b_en, irq_a_level, irq_b_level, other_irq, irq_return,
        output vcc_up, ext_move, ext_exec,
        input sfr_rdata, core_clk_en, osc_run, ram_block, int_reset, hold_ports,
        input ale_o, ale_oe, prog_store_strobe, idle_flag, pdown_flag,
        input baud_doubler, frame_err_select
    );
endinterface : pmc_if

// ===== rtl/pmc_host.sv
// Core/pin side end: Wishbone-driven orders toward the power-mode block
`timescale 1ns/1ps
module pmc_host
    import pmc_pkg::*;
#(
    parameter int RESET_HOLD = RESET_HOLD_OSC,
    parameter int WAKE_HOLD = OSC_RESTART_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    pmc_if.host LINK,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] resp;
        logic [7:0] ctl;
        logic busy;
        cmd_t cmd;
        logic [16:0] cnt;
        logic wr;
        logic rd;
        logic rst_pin;
        logic irq_a_n;
        logic vcc;
    } host_st_t;

    host_st_t cur_ff;
    host_st_t nxt_ff;
    logic req;

    // Command engine and Wishbone slave
    always_comb begin
        req = WB_CYC_I && WB_STB_I && !cur_ff.ack;
        nxt_ff = cur_ff;
        nxt_ff.ack = req;
        nxt_ff.wr = 1'b0;
        nxt_ff.rd = 1'b0;
        if (req) begin
            if (WB_ADR_I == WB_CMD_ADDR) begin
                nxt_ff.dat = {29'h0, cur_ff.cmd};
                if (WB_WE_I && WB_SEL_I[0] && !cur_ff.busy) begin
                    nxt_ff.cmd = cmd_t'(WB_DAT_I[2:0]);
                    nxt_ff.busy = 1'b1;
                    nxt_ff.cnt = 17'h0;
                end
            end else if (WB_ADR_I == WB_DATA_ADDR) begin
                nxt_ff.dat = {16'h0, cur_ff.addr, cur_ff.wdata};
                if (WB_WE_I && WB_SEL_I[0]) begin
                    nxt_ff.wdata = WB_DAT_I[7:0]; // bit 5 must be zero
                end
                if (WB_WE_I && WB_SEL_I[1]) begin
                    nxt_ff.addr = WB_DAT_I[15:8];
                end
            end else if (WB_ADR_I == WB_STAT_ADDR) begin
                nxt_ff.dat = {24'h0, LINK.idle_flag, LINK.pdown_flag, LINK.osc_run,
                    LINK.core_clk_en, LINK.ram_block, 2'b00, cur_ff.busy};
            end else if (WB_ADR_I == WB_RESP_ADDR) begin
                nxt_ff.dat = {16'h0, cur_ff.ctl, cur_ff.resp};
                if (WB_WE_I && WB_SEL_I[1]) begin
                    nxt_ff.ctl = WB_DAT_I[15:8];
                end
            end else begin
                nxt_ff.dat = 32'h0;
            end
        end
        if (cur_ff.busy) begin
            nxt_ff.cnt = cur_ff.cnt + 17'h1;
            case (cur_ff.cmd)
                CMD_WRITE: begin
                    nxt_ff.wr = 1'b1;
                    nxt_ff.busy = 1'b0;
                end
                CMD_READ: begin
                    nxt_ff.rd = (cur_ff.cnt == 17'h0);
                    if (cur_ff.cnt == 17'h2) begin
                        nxt_ff.resp = LINK.sfr_rdata;
                        nxt_ff.busy = 1'b0;
                    end
                end
                CMD_RESET: begin
                    nxt_ff.rst_pin = 1'b1;
                    if (cur_ff.cnt == 17'(RESET_HOLD)) begin
                        nxt_ff.rst_pin = 1'b0;
                        nxt_ff.busy = 1'b0;
                    end
                end
                CMD_IRQ: begin
                    nxt_ff.irq_a_n = 1'b0;
                    if (cur_ff.cnt == 17'(WAKE_HOLD)) begin
                        nxt_ff.irq_a_n = 1'b1;
                        nxt_ff.busy = 1'b0;
                    end
                end
                CMD_POWER: begin
                    nxt_ff.vcc = cur_ff.ctl[0];
                    nxt_ff.busy = 1'b0;
                end
                default: begin
                    nxt_ff.busy = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cur_ff <= '0;
            cur_ff.irq_a_n <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Link and bus outputs
    always_comb begin
        WB_ACK_O = cur_ff.ack;
        WB_DAT_O = cur_ff.dat;
        LINK.sfr_wr = cur_ff.wr;
        LINK.sfr_rd = cur_ff.rd;
        LINK.sfr_addr = cur_ff.addr;
        LINK.sfr_wdata = cur_ff.wdata;
        LINK.rst_pin = cur_ff.rst_pin;
        LINK.irq_a_n = cur_ff.irq_a_n;
        LINK.irq_b_n = 1'b1;
        LINK.irq_a_en = cur_ff.ctl[1];
        LINK.irq_b_en = 1'b0;
        LINK.irq_a_level = cur_ff.ctl[2];
        LINK.irq_b_level = 1'b0;
        LINK.other_irq = cur_ff.ctl[3];
        LINK.irq_return = 1'b0;
        LINK.vcc_up = cur_ff.vcc;
        LINK.ext_move = cur_ff.ctl[4];
        LINK.ext_exec = cur_ff.ctl[5];
    end
endmodule : pmc_host

// ===== test/pmc_link_sva.sv
// Checker for the power-mode link between host and device ends
`timescale 1ns/1ps
module pmc_link_sva
    import pmc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic rst_pin,
    input wire logic irq_a_n,
    input wire logic irq_a_en,
    input wire logic irq_a_level,
    input wire logic other_irq,
    input wire logic core_clk_en,
    input wire logic osc_run,
    input wire logic ram_block,
    input wire logic int_reset,
    input wire logic ale_o,
    input wire logic ale_oe,
    input wire logic prog_store_strobe,
    input wire logic idle_flag,
    input wire logic pdown_flag,
    input wire logic baud_doubler,
    input wire logic frame_err_select
);
    logic run_wr;
    // Control write taken while running
    assign run_wr = sfr_wr && sfr_addr == POWER_CONTROL_ADDR && !idle_flag && !pdown_flag && !ram_block && !int_reset;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    AST_IDLE_CLK: assert property (idle_flag |-> !core_clk_en && osc_run)
        else $error("idle without core clock gating");
    AST_IDLE_STROBE: assert property (idle_flag |-> prog_store_strobe && (ale_o || !ale_oe))
        else $error("strobes not high in idle");
    AST_IRQ_WAKE: assert property (idle_flag && other_irq |-> ##[1:13] !idle_flag)
        else $error("idle not left on interrupt");
    AST_RST_IDLE: assert property (rst_pin && idle_flag |=> !idle_flag && ram_block)
        else $error("reset pin did not end idle");
    AST_LEAD: assert property ($rose(ram_block) |-> ##[25:37] int_reset)
        else $error("internal reset late after lead");
    AST_PD_OSC: assert property (pdown_flag |-> !osc_run && !core_clk_en)
        else $error("oscillator running in power-down");
    AST_PD_STROBE: assert property (pdown_flag |-> !prog_store_strobe && ale_oe && !ale_o)
        else $error("strobes not low in power-down");
    AST_PD_WAKE: assert property (pdown_flag && irq_a_en && irq_a_level && !irq_a_n |-> ##[1:40] !pdown_flag)
        else $error("power-down not left on level interrupt");
    AST_BOTH: assert property (run_wr && sfr_wdata[PDOWN_BIT] |=> pdown_flag && !idle_flag)
        else $error("power-down bit did not take precedence");
    AST_BAUD: assert property (run_wr |=> {baud_doubler, frame_err_select} == $past(sfr_wdata[7:6]))
        else $error("serial control bits not mirrored");
endmodule : pmc_link_sva

// ===== test/tb_top.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module tb_top;
    import pmc_pkg::*;
    logic clock, sys_rst, wb_we, wb_cyc, wb_stb, wb_ack;
    logic [3:0] wb_adr, wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [7:0] v, st;
    int num_errors, compares, power_control, i;
    pmc_if link_if ();
    pmc_device pmc_device_inst (.CLOCK(clock), .SYS_RST(sys_rst), .LINK(link_if), .MODE(), .STATE_IN_MC());
    pmc_host #(.WAKE_HOLD(20)) pmc_host_inst (.CLOCK(clock), .SYS_RST(sys_rst), .LINK(link_if),
        .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o), .WB_WE_I(wb_we), .WB_SEL_I(wb_sel),
        .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack));
    pmc_link_sva pmc_link_sva_inst (.CLOCK(clock), .SYS_RST(sys_rst), .sfr_wr(link_if.sfr_wr),
        .sfr_addr(link_if.sfr_addr), .sfr_wdata(link_if.sfr_wdata), .rst_pin(link_if.rst_pin),
        .irq_a_n(link_if.irq_a_n), .irq_a_en(link_if.irq_a_en), .irq_a_level(link_if.irq_a_level),
        .other_irq(link_if.other_irq), .core_clk_en(link_if.core_clk_en), .osc_run(link_if.osc_run),
        .ram_block(link_if.ram_block), .int_reset(link_if.int_reset), .ale_o(link_if.ale_o),
        .ale_oe(link_if.ale_oe), .prog_store_strobe(link_if.prog_store_strobe),
        .idle_flag(link_if.idle_flag), .pdown_flag(link_if.pdown_flag),
        .baud_doubler(link_if.baud_doubler), .frame_err_select(link_if.frame_err_select));
    // Free-running clock
    always #50 clock = ~clock;
    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // Register value compare
    task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (exp !== got) begin
            num_errors++;
            $display("MISMATCH reg t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_reg
    // Status compare under a mask
    task automatic chk_stat(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (exp !== (got & 8'hF8)) begin
            num_errors++;
            $display("MISMATCH stat t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_stat
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic we, input logic [3:0] s);
        int n;
        n = 0;
        wb_adr <= a;
        wb_dat_i <= d;
        wb_we <= we;
        wb_sel <= s;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(negedge clock);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            final_report();
        end
        q = wb_dat_o;
        @(posedge clock);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask : wb
    // Status read and wait for the host to go quiet
    task automatic stat;
        int n;
        n = 0;
        do begin
            wb(4'h8, 32'h0, 1'b0, 4'hF);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        if (n >= 500) begin
            num_errors++;
            final_report();
        end
        st = q[7:0];
    endtask : stat
    // Host order, then wait until done
    task automatic cmd(input logic [2:0] c);
        wb(4'h0, {29'h0, c}, 1'b1, 4'h1);
        stat();
    endtask : cmd
    // Control byte toward pins and levels
    task automatic ctl(input logic [7:0] c);
        wb(4'hC, {16'h0, c, 8'h0}, 1'b1, 4'h2);
    endtask : ctl
    // Register write across the link
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        wb(4'h4, {16'h0, a, d}, 1'b1, 4'h3);
        cmd(3'h1);
    endtask : sfr_w
    // Register read across the link
    task automatic sfr_r(input logic [7:0] a);
        wb(4'h4, {16'h0, a, 8'h0}, 1'b1, 4'h3);
        cmd(3'h2);
        wb(4'hC, 32'h0, 1'b0, 4'hF);
        v = q[7:0];
    endtask : sfr_r
    // Watchdog against hangs
    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        final_report();
    end
    // Main sequence
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {wb_we, wb_cyc, wb_stb, wb_adr, wb_sel, wb_dat_i} = '0;
        void'($urandom(32'h3F84FD23));
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        // Supply rise marks a cold start
        ctl(8'h00);
        cmd(3'h5);
        ctl(8'h31);
        cmd(3'h5);
        power_control = 8'h10;
        sfr_r(POWER_CONTROL_ADDR);
        chk_reg(power_control[7:0], v);
        sfr_r(AUXILIARY_CONTROL_ADDR);
        chk_reg(AUXILIARY_CONTROL_RESET, v);
        stat();
        chk_stat(8'h30, st);
        $display("test cold start done");
        // Random flag and serial bit values
        for (i = 0; i < 4; i++) begin
            power_control = $urandom & 8'hDC;
            sfr_w(POWER_CONTROL_ADDR, power_control[7:0]);
            sfr_r(POWER_CONTROL_ADDR);
            chk_reg(power_control[7:0], v);
            chk_reg({6'h0, link_if.baud_doubler, link_if.frame_err_select}, {6'h0, power_control[7:6]});
            sfr_w(AUXILIARY_CONTROL_ADDR, {7'h0, power_control[2]});
            sfr_r(AUXILIARY_CONTROL_ADDR);
            chk_reg({7'h0, power_control[2]}, v);
        end
        $display("test flags done");
        // Idle entry and interrupt exit
        ctl(8'h01);
        sfr_w(POWER_CONTROL_ADDR, power_control[7:0] | 8'h01);
        stat();
        chk_stat(8'hA0, st);
        ctl(8'h09);
        stat();
        chk_stat(8'h30, st);
        ctl(8'h01);
        sfr_r(POWER_CONTROL_ADDR);
        chk_reg(power_control[7:0], v);
        $display("test idle done");
        // Both mode bits, then level interrupt wake
        sfr_w(POWER_CONTROL_ADDR, power_control[7:0] | 8'h03);
        stat();
        chk_stat(8'h40, st);
        ctl(8'h07);
        cmd(3'h3);
        stat();
        chk_stat(8'h30, st);
        sfr_r(POWER_CONTROL_ADDR);
        chk_reg(power_control[7:0], v);
        ctl(8'h01);
        $display("test power-down done");
        // Idle left by reset pin, flags cleared but cold flag kept
        sfr_w(POWER_CONTROL_ADDR, power_control[7:0] | 8'h01);
        cmd(3'h4);
        repeat (60) @(posedge clock);
        stat();
        chk_stat(8'h30, st);
        sfr_r(POWER_CONTROL_ADDR);
        chk_reg(power_control[7:0] & 8'h10, v);
        $display("test idle reset done");
        final_report();
    end
endmodule : tb_top
